// [logic/dcc_pkg.sv]
package dcc_pkg;

   // Mask-configured clock source combinations.
   localparam logic [1:0] OPT_FAST_ONLY = 2'h1;
   localparam logic [1:0] OPT_SLOW_ONLY = 2'h2;
   localparam logic [1:0] OPT_DUAL      = 2'h3;

   // Mask-configured fast oscillator types.
   localparam logic [2:0] FTYPE_IRC_LOW  = 3'h1;
   localparam logic [2:0] FTYPE_IRC_HIGH = 3'h2;
   localparam logic [2:0] FTYPE_EXT_RES  = 3'h3;
   localparam logic [2:0] FTYPE_CERAMIC  = 3'h4;

   // Nominal internal RC frequencies in kHz; zero means not an internal RC.
   localparam logic [9:0] IRC_LOW_KHZ  = 10'h0FA;
   localparam logic [9:0] IRC_HIGH_KHZ = 10'h1F4;
   localparam logic [9:0] NO_RC_KHZ    = 10'h000;

   // Settling counts, in cycles of the oscillator being switched to.
   localparam logic [4:0] FAST_SETTLE_CYCLES = 5'h0C;
   localparam logic [4:0] SLOW_SETTLE_CYCLES = 5'h02;
   // Length of the initial reset cycle, in peripheral clock cycles.
   localparam int         INIT_CYCLES_DEFAULT = 16;

   // Reset values.
   localparam logic       BOOST_RESET = 1'b1;

   // Run states of the clock controller.
   typedef enum logic [2:0] {
      ST_INIT      = 3'b000,
      ST_SLOW      = 3'b001,
      ST_FAST_WAIT = 3'b010,
      ST_FAST      = 3'b011,
      ST_SLOW_WAIT = 3'b100,
      ST_HALT      = 3'b101,
      ST_STOP      = 3'b110
   } dcc_state_t;

   // One-cycle requests from the instruction decoder.
   typedef struct packed {
      logic fast_req;
      logic slow_req;
      logic halt_req;
      logic stop_req;
      logic wake_req;
   } dcc_cmd_t;

   // Controls toward the analog oscillator circuits.
   typedef struct packed {
      logic slow_en;
      logic slow_boost;
      logic fast_en;
   } dcc_osc_ctrl_t;

endpackage : dcc_pkg

// [logic/dcc_clock_ctrl.sv]
// What this block does
// - Boost flag set during initial reset cycle
// - Boost flag drives slow oscillator increased drive
// - Single option: both clocks from that oscillator
// - Dual: divider slow; instruction fast in fast and slow wait
// - Slow oscillator off if fast-only, else running
// - Stop entry disables slow oscillator
// - Slow clock feeds peripherals unless fast-only
// - Fast clock feeds all if fast-only, else instruction
// - Dual: fast oscillator off until FAST instruction
// - FAST moves only instruction clock to fast
// - Halt, stop, SLOW (dual): fast off, source slow
// - Accept fast oscillator type configuration
// - Wait 12 fast cycles before switching fast
// - Wait 2 slow cycles before switching slow
// - Single options: FAST and SLOW are no-ops
`timescale 1ns/1ps
module dcc_clock_ctrl #(
   parameter int INIT_CYCLES = dcc_pkg::INIT_CYCLES_DEFAULT
) (
   input  wire  logic                   mclk,
   input  wire  logic                   rst,
   input  wire  logic [1:0]             clock_option,
   input  wire  logic [2:0]             fast_osc_type,
   input  wire  dcc_pkg::dcc_cmd_t      cmd,
   input  wire  logic                   boost_clear,
   input  wire  logic                   slow_osc_clock,
   input  wire  logic                   fast_osc_clock,
   output dcc_pkg::dcc_osc_ctrl_t       osc_ctrl,
   output logic                         osc_boost_flag,
   output logic                         instr_clock,
   output logic                         divider_input_clock,
   output logic                         periph_clock,
   output logic                         instr_src_fast,
   output dcc_pkg::dcc_state_t          run_state,
   output logic [9:0]                   fast_rc_khz
);
   import dcc_pkg::*;

   localparam logic [4:0] INIT_LAST = 5'(INIT_CYCLES - 1);

   logic          s_sync1_reg;
   logic          s_sync2_reg;
   logic          s_prev_reg;
   logic          f_sync1_reg;
   logic          f_sync2_reg;
   logic          f_prev_reg;
   logic          s_rise;
   logic          f_rise;
   logic          p_rise;
   logic [1:0]    opt_reg;
   logic [2:0]    ftype_reg;
   dcc_state_t    state_reg;
   dcc_state_t    state_next;
   logic [4:0]    cnt_reg;
   logic [4:0]    cnt_next;
   logic          boost_reg;
   logic          boost_next;
   logic          mux_sel_reg;
   logic          mux_sel_next;
   logic          target_fast;
   dcc_osc_ctrl_t osc_reg;
   dcc_osc_ctrl_t osc_next;
   logic          instr_reg;
   logic          instr_next;
   logic          div_reg;
   logic          div_next;
   logic [9:0]    khz_reg;
   logic [9:0]    khz_next;
   logic          is_dual;
   logic          is_fast_only;

   // Oscillator pins are asynchronous to mclk, so each passes two flops first.
   always_ff @(posedge mclk)
   begin
      s_sync1_reg <= slow_osc_clock;
      s_sync2_reg <= s_sync1_reg;
      s_prev_reg  <= s_sync2_reg;
      f_sync1_reg <= fast_osc_clock;
      f_sync2_reg <= f_sync1_reg;
      f_prev_reg  <= f_sync2_reg;
   end

   // Rising edges of the sampled oscillator clocks.
   assign s_rise       = s_sync2_reg & ~s_prev_reg;
   assign f_rise       = f_sync2_reg & ~f_prev_reg;
   assign is_dual      = (opt_reg == OPT_DUAL);
   assign is_fast_only = (opt_reg == OPT_FAST_ONLY);
   assign p_rise       = is_fast_only ? f_rise : s_rise;

   // Mask options are caught while reset is held and frozen afterwards.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         opt_reg   <= clock_option;
         ftype_reg <= fast_osc_type;
      end
   end

   // Run state sequencing; stop outranks halt, both outrank FAST and SLOW.
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         ST_INIT:
         begin
            if (p_rise)
            begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == INIT_LAST)
               begin
                  cnt_next   = 5'h00;
                  state_next = is_fast_only ? ST_FAST : ST_SLOW;
               end
            end
         end
         ST_SLOW:
         begin
            if (cmd.stop_req)
               state_next = ST_STOP;
            else if (cmd.halt_req)
               state_next = ST_HALT;
            else if (cmd.fast_req && is_dual)
            begin
               state_next = ST_FAST_WAIT;
               cnt_next   = 5'h00;
            end
         end
         ST_FAST_WAIT:
         begin
            if (cmd.stop_req)
               state_next = ST_STOP;
            else if (cmd.halt_req)
               state_next = ST_HALT;
            else if (cmd.slow_req)
               state_next = ST_SLOW;
            else if (f_rise)
            begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == FAST_SETTLE_CYCLES - 5'h01)
               begin
                  cnt_next   = 5'h00;
                  state_next = ST_FAST;
               end
            end
         end
         ST_FAST:
         begin
            if (cmd.stop_req)
               state_next = ST_STOP;
            else if (cmd.halt_req)
               state_next = ST_HALT;
            else if (cmd.slow_req && is_dual)
            begin
               state_next = ST_SLOW_WAIT;
               cnt_next   = 5'h00;
            end
         end
         ST_SLOW_WAIT:
         begin
            if (cmd.stop_req)
               state_next = ST_STOP;
            else if (cmd.halt_req)
               state_next = ST_HALT;
            else if (s_rise)
            begin
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == SLOW_SETTLE_CYCLES - 5'h01)
               begin
                  cnt_next   = 5'h00;
                  state_next = ST_SLOW;
               end
            end
         end
         ST_HALT, ST_STOP:
         begin
            if (cmd.wake_req)
               state_next = is_fast_only ? ST_FAST : ST_SLOW;
         end
         default:
         begin
            state_next = ST_INIT;
            cnt_next   = 5'h00;
         end
      endcase
   end

   // The boost flag is forced high in the initial cycle, so software cannot
   // clear it there; afterwards a clear request drops it.
   always_comb
   begin
      if (state_next == ST_INIT)
         boost_next = 1'b1;
      else if (boost_clear)
         boost_next = 1'b0;
      else
         boost_next = boost_reg;
   end

   // Oscillator enables follow the next state so they align with run_state.
   always_comb
   begin
      osc_next.slow_en    = !is_fast_only && (state_next != ST_STOP);
      osc_next.slow_boost = boost_next;
      if (is_fast_only)
         osc_next.fast_en = (state_next != ST_STOP);
      else if (is_dual)
         osc_next.fast_en = (state_next == ST_FAST_WAIT) || (state_next == ST_FAST)
                            || (state_next == ST_SLOW_WAIT);
      else
         osc_next.fast_en = 1'b0;
   end

   // Source wanted for the instruction clock; the fast-only option, and under the
   // dual option the fast state and the hold after a SLOW request, keep it on the fast clock.
   always_comb
   begin
      target_fast = is_fast_only || (is_dual && (state_reg == ST_FAST
                    || state_reg == ST_SLOW_WAIT));
   end

   // The selector only moves while the outgoing and incoming clocks are both
   // low, so the output never shows a sliver of either source. A disabled
   // fast oscillator may park high, so it is not waited for.
   always_comb
   begin
      mux_sel_next = mux_sel_reg;
      if ((target_fast != mux_sel_reg) && !s_sync2_reg
          && (!f_sync2_reg || !osc_reg.fast_en))
         mux_sel_next = target_fast;
      instr_next = mux_sel_reg ? f_sync2_reg : s_sync2_reg;
   end

   // Divider and peripheral clocks come from the slow oscillator except
   // under the fast-only option.
   always_comb
   begin
      div_next = is_fast_only ? f_sync2_reg : s_sync2_reg;
   end

   // Nominal frequency of the configured fast oscillator type.
   always_comb
   begin
      unique case (ftype_reg)
         FTYPE_IRC_LOW:  khz_next = IRC_LOW_KHZ;
         FTYPE_IRC_HIGH: khz_next = IRC_HIGH_KHZ;
         default:        khz_next = NO_RC_KHZ;
      endcase
   end

   // All control state registers; reset enters the initial cycle.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_reg   <= ST_INIT;
         cnt_reg     <= 5'h00;
         boost_reg   <= BOOST_RESET;
         mux_sel_reg <= 1'b0;
         osc_reg     <= '{slow_en: 1'b0, slow_boost: BOOST_RESET, fast_en: 1'b0};
         instr_reg   <= 1'b0;
         div_reg     <= 1'b0;
         khz_reg     <= NO_RC_KHZ;
      end
      else
      begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         boost_reg   <= boost_next;
         mux_sel_reg <= mux_sel_next;
         osc_reg     <= osc_next;
         instr_reg   <= instr_next;
         div_reg     <= div_next;
         khz_reg     <= khz_next;
      end
   end

   // Outputs are all taken straight from flops.
   assign osc_ctrl            = osc_reg;
   assign osc_boost_flag      = boost_reg;
   assign instr_clock         = instr_reg;
   assign divider_input_clock = div_reg;
   assign periph_clock        = div_reg;
   assign instr_src_fast      = mux_sel_reg;
   assign run_state           = state_reg;
   assign fast_rc_khz         = khz_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_boost_init: assert property (state_reg == ST_INIT |-> boost_reg)
      else $error("boost flag low in initial cycle");
   chk_boost_drive: assert property (osc_reg.slow_boost == boost_reg)
      else $error("slow drive does not follow boost flag");
   chk_slow_single: assert property (opt_reg == OPT_SLOW_ONLY |-> !mux_sel_reg
      ##1 div_reg == $past(s_sync2_reg))
      else $error("slow-only clocks not from slow oscillator");
   chk_dual_divider: assert property (is_dual |=> div_reg == $past(s_sync2_reg))
      else $error("dual divider clock not slow");
   chk_slow_off: assert property (is_fast_only |-> !osc_reg.slow_en)
      else $error("slow oscillator on in fast-only");
   chk_stop_slow: assert property (state_reg == ST_STOP |-> !osc_reg.slow_en)
      else $error("slow oscillator on in stop");
   chk_fast_gate: assert property (is_dual && state_reg == ST_SLOW |-> !osc_reg.fast_en)
      else $error("fast oscillator on in slow state");
   chk_halt_fast: assert property (is_dual && (state_reg == ST_HALT
      || state_reg == ST_STOP) |-> !osc_reg.fast_en)
      else $error("fast oscillator on in halt or stop");
   chk_fast_settle: assert property ($rose(state_reg == ST_FAST) && is_dual
      |-> $past(state_reg) == ST_FAST_WAIT && $past(cnt_reg) == 5'h0B)
      else $error("fast switch without settling");
   chk_slow_settle: assert property ($past(state_reg) == ST_SLOW_WAIT
      && state_reg == ST_SLOW |-> $past(cnt_reg) == 5'h01)
      else $error("slow switch without settling");
   chk_single_nop: assert property (!is_dual && state_reg == ST_SLOW && cmd.fast_req
      && !cmd.halt_req && !cmd.stop_req |=> state_reg == ST_SLOW)
      else $error("FAST acted under single option");
   chk_mux_glitch: assert property ($changed(mux_sel_reg) && $past(osc_reg.fast_en)
      |-> !instr_reg)
      else $error("clock source switched while high");
   chk_slow_hold: assert property (is_dual && state_reg == ST_SLOW_WAIT
      |=> !$fell(mux_sel_reg))
      else $error("source left fast clock before slow hold ended");

   cov_fast_entry: cover property (is_dual && state_reg == ST_FAST && mux_sel_reg);
   cov_back_slow: cover property (state_reg == ST_SLOW_WAIT ##[1:1000] state_reg == ST_SLOW);
   cov_halt_wake: cover property (state_reg == ST_HALT ##1 state_reg == ST_SLOW);
   cov_stop_entry: cover property (state_reg == ST_FAST ##1 state_reg == ST_STOP);

endmodule : dcc_clock_ctrl

// [verif/dcc_osc_model.sv]
`timescale 1ns/1ps
// Behavioural oscillator pair: each runs only while its enable is high.
module dcc_osc_model #(
   parameter int SLOW_HALF = 80,
   parameter int FAST_HALF = 31
) (
   input  wire dcc_pkg::dcc_osc_ctrl_t osc_ctrl,
   output logic                        slow_osc_clock,
   output logic                        fast_osc_clock
);
   import dcc_pkg::*;

   // A stopped oscillator rests low, so no stale level looks like a live clock.
   always
   begin
      slow_osc_clock = 1'h0;
      wait (osc_ctrl.slow_en === 1'h1);
      // Half a nanosecond of offset keeps every oscillator edge off an mclk edge.
      #0.5;
      while (osc_ctrl.slow_en === 1'h1)
         #(SLOW_HALF) slow_osc_clock = ~slow_osc_clock;
   end

   // The fast half period is not a divisor of the slow one, so phases drift.
   always
   begin
      fast_osc_clock = 1'h0;
      wait (osc_ctrl.fast_en === 1'h1);
      #0.5;
      while (osc_ctrl.fast_en === 1'h1)
         #(FAST_HALF) fast_osc_clock = ~fast_osc_clock;
   end
endmodule : dcc_osc_model

// [verif/dual_clock_source_control_test.sv]
`timescale 1ns/1ps
module dual_clock_source_control_test;
   import dcc_pkg::*;
   logic          mclk;
   logic          rst;
   logic [1:0]    clock_option;
   logic [2:0]    fast_osc_type;
   dcc_cmd_t      cmd;
   logic          boost_clear;
   logic          slow_osc_clock;
   logic          fast_osc_clock;
   dcc_osc_ctrl_t osc_ctrl;
   logic          osc_boost_flag;
   logic          instr_clock;
   logic          divider_input_clock;
   logic          periph_clock;
   logic          instr_src_fast;
   dcc_state_t    run_state;
   dcc_state_t    prev_state;
   logic [9:0]    fast_rc_khz;
   dcc_state_t    exp_q[$];
   logic [31:0]   seed;
   int            error_cnt;
   int            checked;
   int            cycles;
   int            n;
   int            a;
   int            b;
   int            s_rises;
   logic          s_last;

   dcc_clock_ctrl #(.INIT_CYCLES(2)) dut (.mclk(mclk), .rst(rst), .clock_option(clock_option),
      .fast_osc_type(fast_osc_type), .cmd(cmd), .boost_clear(boost_clear),
      .slow_osc_clock(slow_osc_clock), .fast_osc_clock(fast_osc_clock), .osc_ctrl(osc_ctrl),
      .osc_boost_flag(osc_boost_flag), .instr_clock(instr_clock),
      .divider_input_clock(divider_input_clock), .periph_clock(periph_clock),
      .instr_src_fast(instr_src_fast), .run_state(run_state), .fast_rc_khz(fast_rc_khz));

   dcc_osc_model osc (.osc_ctrl(osc_ctrl), .slow_osc_clock(slow_osc_clock),
      .fast_osc_clock(fast_osc_clock));

   always #5 mclk = ~mclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask : tick

   // A second command may follow at the very next edge; the strobe is never set twice.
   task automatic pulse(input dcc_cmd_t c, input dcc_cmd_t c2);
      @(posedge mclk) cmd <= c;
      if (c2 != '0)
         @(posedge mclk) cmd <= c2;
      @(posedge mclk) cmd <= '0;
   endtask : pulse

   // Waits for a state and counts raw rises of the oscillator that gates it.
   task automatic wait_for(input dcc_state_t st, input logic use_fast, output int r);
      logic p;
      logic c;
      r = 0;
      p = use_fast ? fast_osc_clock : slow_osc_clock;
      for (int i = 0; i < 3000 && run_state !== st; i++)
      begin
         @(posedge mclk);
         c = use_fast ? fast_osc_clock : slow_osc_clock;
         if (c && !p)
            r++;
         p = c;
      end
      chk("state_reached", st, run_state);
   endtask : wait_for

   // Counts instruction and divider clock rises over k cycles.
   task automatic count(input int k, output int ra, output int rb);
      logic pa;
      logic pb;
      ra = 0;
      rb = 0;
      pa = instr_clock;
      pb = divider_input_clock;
      repeat (k)
      begin
         @(posedge mclk);
         if (instr_clock && !pa)
            ra++;
         if (divider_input_clock && !pb)
            rb++;
         pa = instr_clock;
         pb = divider_input_clock;
      end
   endtask : count

   task automatic reset_to(input logic [1:0] opt, input logic [2:0] typ, input dcc_state_t st);
      @(posedge mclk);
      rst <= 1'h1;
      clock_option <= opt;
      fast_osc_type <= typ;
      exp_q.delete();
      tick(16);
      chk("boost_in_reset", 1'h1, osc_boost_flag);
      exp_q.push_back(st);
      rst <= 1'h0;
      wait_for(st, 1'h0, n);
   endtask : reset_to

   // Every state change outside the initial cycle must match the oldest note.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         tally_and_finish();
      end
      if (!rst && run_state !== prev_state && run_state !== ST_INIT)
      begin
         if (exp_q.size() == 0)
            chk("run_state", 10'h3FF, run_state);
         else
            chk("run_state", exp_q.pop_front(), run_state);
      end
      prev_state <= run_state;
      if (!rst)
         chk("periph", divider_input_clock, periph_clock);
      // Raw slow rises, counted free-running so a wait can be measured from its request.
      if (slow_osc_clock && !s_last)
         s_rises <= s_rises + 1;
      s_last <= slow_osc_clock;
   end

   initial
   begin
      mclk = 1'h0;
      rst = 1'h1;
      clock_option = OPT_DUAL;
      fast_osc_type = FTYPE_IRC_LOW;
      cmd = '0;
      boost_clear = 1'h0;
      seed = 32'h00018501;
      reset_to(OPT_DUAL, FTYPE_IRC_LOW, ST_SLOW);
      chk("khz", IRC_LOW_KHZ, fast_rc_khz);
      chk("fast_en", 1'h0, osc_ctrl.fast_en);
      chk("slow_en", 1'h1, osc_ctrl.slow_en);
      chk("boost_drive", 1'h1, osc_ctrl.slow_boost);
      tick(1 + rnd() % 8);
      @(posedge mclk) boost_clear <= 1'h1;
      @(posedge mclk) boost_clear <= 1'h0;
      tick(1);
      chk("boost", 1'h0, osc_boost_flag);
      chk("boost_drive", 1'h0, osc_ctrl.slow_boost);
      $display("test boost done");
      exp_q.push_back(ST_FAST_WAIT);
      exp_q.push_back(ST_FAST);
      pulse(5'h10, '0);
      tick(1);
      chk("fast_en", 1'h1, osc_ctrl.fast_en);
      wait_for(ST_FAST, 1'h1, n);
      chk("fast_settle", 1'h1, n >= 12 && n <= 14);
      tick(40);
      chk("src_fast", 1'h1, instr_src_fast);
      chk("slow_en", 1'h1, osc_ctrl.slow_en);
      count(300, a, b);
      chk("instr_faster", 1'h1, a > b && b > 0);
      exp_q.push_back(ST_SLOW_WAIT);
      exp_q.push_back(ST_SLOW);
      a = s_rises;
      pulse(5'h08, '0);
      tick(4);
      chk("src_hold", 1'h1, instr_src_fast);
      wait_for(ST_SLOW, 1'h0, n);
      chk("slow_settle", 1'h1, s_rises - a >= 2 && s_rises - a <= 3);
      tick(40);
      chk("fast_en", 1'h0, osc_ctrl.fast_en);
      chk("src_fast", 1'h0, instr_src_fast);
      $display("test fast_slow done");
      exp_q.push_back(ST_FAST_WAIT);
      exp_q.push_back(ST_FAST);
      exp_q.push_back(ST_HALT);
      exp_q.push_back(ST_SLOW);
      pulse(5'h10, '0);
      wait_for(ST_FAST, 1'h1, n);
      pulse(5'h04, '0);
      tick(1);
      chk("fast_en", 1'h0, osc_ctrl.fast_en);
      tick(40);
      chk("src_fast", 1'h0, instr_src_fast);
      tick(1 + rnd() % 8);
      pulse(5'h01, '0);
      wait_for(ST_SLOW, 1'h0, n);
      exp_q.push_back(ST_FAST_WAIT);
      exp_q.push_back(ST_FAST);
      exp_q.push_back(ST_STOP);
      exp_q.push_back(ST_SLOW);
      pulse(5'h10, '0);
      wait_for(ST_FAST, 1'h1, n);
      pulse(5'h02, '0);
      tick(1);
      chk("slow_en", 1'h0, osc_ctrl.slow_en);
      chk("fast_en", 1'h0, osc_ctrl.fast_en);
      pulse(5'h01, '0);
      wait_for(ST_SLOW, 1'h0, n);
      exp_q.push_back(ST_FAST_WAIT);
      exp_q.push_back(ST_SLOW);
      pulse(5'h10, 5'h08);
      tick(2);
      chk("fast_en", 1'h0, osc_ctrl.fast_en);
      $display("test halt_stop done");
      reset_to(OPT_SLOW_ONLY, FTYPE_IRC_HIGH, ST_SLOW);
      chk("khz", IRC_HIGH_KHZ, fast_rc_khz);
      repeat (4) pulse(rnd() % 2 ? 5'h10 : 5'h08, '0);
      count(300, a, b);
      chk("slow_only", 1'h1, b > 0 && !instr_src_fast && !osc_ctrl.fast_en);
      reset_to(OPT_FAST_ONLY, FTYPE_EXT_RES, ST_FAST);
      chk("khz", NO_RC_KHZ, fast_rc_khz);
      chk("slow_en", 1'h0, osc_ctrl.slow_en);
      repeat (4) pulse(rnd() % 2 ? 5'h10 : 5'h08, '0);
      count(300, a, b);
      chk("fast_only", 1'h1, a > 0 && b > 0 && instr_src_fast);
      reset_to(OPT_DUAL, FTYPE_CERAMIC, ST_SLOW);
      chk("khz", NO_RC_KHZ, fast_rc_khz);
      $display("test options done");
      tally_and_finish();
   end
endmodule : dual_clock_source_control_test
